//--- rtl/rbt_transceiver.sv
// Behaviour
// - Seventeen bits each way between A and B, one storage bit per bit per direction.
// - A-to-B latch enable high with outputs enabled: B follows A.
// - Latch enable low, clock enable low, clock steady: stored data stays on B.
// - Latch enable low, clock enable low: rising A-to-B clock captures A and drives B.
// - Clock enable high, latch enable low: clock edges ignored, output held.
// - B driven while A-to-B output enable low, floating while high.
// - B-to-A direction works the same with its own four controls.
// - Latched storage holds the level present when the latch enable fell.
// - A-to-B clock is forwarded to a backplane clock output.
// - Backplane clock is passed through to a card-side clock output.
// - Undriven A inputs keep their last valid level.
module rbt_transceiver #(
  parameter int unsigned WIDTH = rbt_pkg::DATA_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bp_clk,
  // Card side
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] a_in_driven,
  output logic [WIDTH-1:0] a_out,
  output logic a_oe_n,
  // Backplane side
  input wire logic [WIDTH-1:0] b_in,
  output logic [WIDTH-1:0] b_out,
  output logic b_oe_n,
  // Direction controls
  input wire logic a_to_b_output_enable_n,
  input wire logic a_to_b_latch_enable,
  input wire logic a_to_b_clock,
  input wire logic a_to_b_clock_enable_n,
  input wire logic b_to_a_output_enable_n,
  input wire logic b_to_a_latch_enable,
  input wire logic b_to_a_clock,
  input wire logic b_to_a_clock_enable_n,
  // Forwarded clocks
  output logic backplane_clock_copy,
  output logic backplane_clock_copy_oe_n,
  output logic card_clock_return,
  output logic card_clock_return_oe_n
);

  localparam int unsigned NCTL = 4;

  // Control synchroniser contents at reset: enables released, latch closed, clock at rest
  localparam logic [NCTL-1:0] CTL_RST = {rbt_pkg::OE_N_RST, rbt_pkg::LE_RST, rbt_pkg::CLK_RST, rbt_pkg::OE_N_RST};

  // Next storage value of one direction
  function automatic logic [WIDTH-1:0] rbt_store_next(
    input logic le,
    input logic ce_n,
    input logic clk_rise,
    input logic [WIDTH-1:0] d,
    input logic [WIDTH-1:0] q
  );
    logic [WIDTH-1:0] r;
    r = q;
    if (le)
    begin
      r = d;
    end
    else if (!ce_n && clk_rise)
    begin
      r = d;
    end
    return r;
  endfunction

  // Value presented at the output of one direction
  function automatic logic [WIDTH-1:0] rbt_out_sel(
    input logic le,
    input logic [WIDTH-1:0] d,
    input logic [WIDTH-1:0] q_next
  );
    logic [WIDTH-1:0] r;
    r = le ? d : q_next;
    return r;
  endfunction

  // Two-flop synchronisers for the data pins
  logic [WIDTH-1:0] a_meta_q;
  logic [WIDTH-1:0] a_sync_q;
  logic [WIDTH-1:0] a_drv_meta_q;
  logic [WIDTH-1:0] a_drv_sync_q;
  logic [WIDTH-1:0] b_meta_q;
  logic [WIDTH-1:0] b_sync_q;

  // A data pins
  always_ff @(posedge clk_sys)
  begin
    a_meta_q <= a_in;
    a_sync_q <= a_meta_q;
  end

  // A drive-sense pins, same latency as the data so both agree per bit
  always_ff @(posedge clk_sys)
  begin
    a_drv_meta_q <= a_in_driven;
    a_drv_sync_q <= a_drv_meta_q;
  end

  // B data pins
  always_ff @(posedge clk_sys)
  begin
    b_meta_q <= b_in;
    b_sync_q <= b_meta_q;
  end

  // Control pins per direction: output enable, latch enable, clock, clock enable
  logic [NCTL-1:0] ctl_pin [rbt_pkg::DIR_N];
  logic [NCTL-1:0] ctl_meta_q [rbt_pkg::DIR_N];
  logic [NCTL-1:0] ctl_sync_q [rbt_pkg::DIR_N];

  always_comb
  begin
    ctl_pin[rbt_pkg::DIR_AB] = {a_to_b_output_enable_n, a_to_b_latch_enable,
                                a_to_b_clock, a_to_b_clock_enable_n};
    ctl_pin[rbt_pkg::DIR_BA] = {b_to_a_output_enable_n, b_to_a_latch_enable,
                                b_to_a_clock, b_to_a_clock_enable_n};
  end

  // A-to-B controls
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctl_meta_q[rbt_pkg::DIR_AB] <= CTL_RST;
      ctl_sync_q[rbt_pkg::DIR_AB] <= CTL_RST;
    end
    else
    begin
      ctl_meta_q[rbt_pkg::DIR_AB] <= ctl_pin[rbt_pkg::DIR_AB];
      ctl_sync_q[rbt_pkg::DIR_AB] <= ctl_meta_q[rbt_pkg::DIR_AB];
    end
  end

  // B-to-A controls
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctl_meta_q[rbt_pkg::DIR_BA] <= CTL_RST;
      ctl_sync_q[rbt_pkg::DIR_BA] <= CTL_RST;
    end
    else
    begin
      ctl_meta_q[rbt_pkg::DIR_BA] <= ctl_pin[rbt_pkg::DIR_BA];
      ctl_sync_q[rbt_pkg::DIR_BA] <= ctl_meta_q[rbt_pkg::DIR_BA];
    end
  end

  logic [rbt_pkg::DIR_N-1:0] oe_n_s;
  logic [rbt_pkg::DIR_N-1:0] le_s;
  logic [rbt_pkg::DIR_N-1:0] clk_s;
  logic [rbt_pkg::DIR_N-1:0] ce_n_s;

  always_comb
  begin
    for (int i = 0; i < rbt_pkg::DIR_N; i++)
    begin
      {oe_n_s[i], le_s[i], clk_s[i], ce_n_s[i]} = ctl_sync_q[i];
    end
  end

  // Previous sampled clock level for rising-edge detection
  logic [rbt_pkg::DIR_N-1:0] clk_prev_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      clk_prev_q <= {rbt_pkg::DIR_N{rbt_pkg::CLK_RST}};
    end
    else
    begin
      clk_prev_q <= clk_s;
    end
  end

  // After reset the sampled clocks read the rest level until real samples
  // have passed both synchroniser flops and the edge register. A pin that
  // idles high would otherwise look like a rising edge and store stale data.
  logic [rbt_pkg::SYNC_STAGES:0] settle_q;
  logic edge_ok;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      settle_q <= '0;
    end
    else
    begin
      settle_q <= {settle_q[rbt_pkg::SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign edge_ok = settle_q[rbt_pkg::SYNC_STAGES];

  logic [rbt_pkg::DIR_N-1:0] clk_rise;
  assign clk_rise = clk_s & ~clk_prev_q & {rbt_pkg::DIR_N{edge_ok}};

  // Bus hold on the card-side inputs
  logic [WIDTH-1:0] a_hold_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      a_hold_q <= rbt_pkg::DATA_RST;
    end
    else
    begin
      for (int k = 0; k < WIDTH; k++)
      begin
        if (a_drv_sync_q[k])
        begin
          a_hold_q[k] <= a_sync_q[k];
        end
      end
    end
  end

  logic [WIDTH-1:0] a_data;
  always_comb
  begin
    for (int k = 0; k < WIDTH; k++)
    begin
      a_data[k] = a_drv_sync_q[k] ? a_sync_q[k] : a_hold_q[k];
    end
  end

  // Storage, one bit per bit per direction
  logic [WIDTH-1:0] store_q [rbt_pkg::DIR_N];
  logic [WIDTH-1:0] store_d [rbt_pkg::DIR_N];
  logic [WIDTH-1:0] dir_in [rbt_pkg::DIR_N];

  always_comb
  begin
    dir_in[rbt_pkg::DIR_AB] = a_data;
    dir_in[rbt_pkg::DIR_BA] = b_sync_q;
    for (int i = 0; i < rbt_pkg::DIR_N; i++)
    begin
      store_d[i] = rbt_store_next(le_s[i], ce_n_s[i], clk_rise[i], dir_in[i], store_q[i]);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      store_q[rbt_pkg::DIR_AB] <= rbt_pkg::DATA_RST;
    end
    else
    begin
      store_q[rbt_pkg::DIR_AB] <= store_d[rbt_pkg::DIR_AB];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      store_q[rbt_pkg::DIR_BA] <= rbt_pkg::DATA_RST;
    end
    else
    begin
      store_q[rbt_pkg::DIR_BA] <= store_d[rbt_pkg::DIR_BA];
    end
  end

  // Both directions may be enabled at once; nothing here blocks it,
  // so the controller must keep the two enables apart.
  // B side: data and enable; values keep updating while the pins float
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      b_out <= rbt_pkg::DATA_RST;
      b_oe_n <= rbt_pkg::OE_N_RST;
    end
    else
    begin
      b_out <= rbt_out_sel(le_s[rbt_pkg::DIR_AB], dir_in[rbt_pkg::DIR_AB], store_d[rbt_pkg::DIR_AB]);
      b_oe_n <= oe_n_s[rbt_pkg::DIR_AB];
    end
  end

  // A side: mirror of the B side for the B-to-A direction
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      a_out <= rbt_pkg::DATA_RST;
      a_oe_n <= rbt_pkg::OE_N_RST;
    end
    else
    begin
      a_out <= rbt_out_sel(le_s[rbt_pkg::DIR_BA], dir_in[rbt_pkg::DIR_BA], store_d[rbt_pkg::DIR_BA]);
      a_oe_n <= oe_n_s[rbt_pkg::DIR_BA];
    end
  end

  // Forwarded copy of the A-to-B clock
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      backplane_clock_copy <= rbt_pkg::CLK_RST;
    end
    else
    begin
      backplane_clock_copy <= clk_s[rbt_pkg::DIR_AB];
    end
  end

  // Its enable tracks the B data enable so both float together
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      backplane_clock_copy_oe_n <= rbt_pkg::OE_N_RST;
    end
    else
    begin
      backplane_clock_copy_oe_n <= oe_n_s[rbt_pkg::DIR_AB];
    end
  end

  // Backplane clock domain: the enable is resynchronised to the backplane clock
  // so the card-side clock pin switches its drive cleanly. The clock itself
  // passes straight through; only the enable gates it.
  logic bp_oe_meta_q;
  logic bp_oe_sync_q;

  always_ff @(posedge bp_clk)
  begin
    bp_oe_meta_q <= b_to_a_output_enable_n;
    bp_oe_sync_q <= bp_oe_meta_q;
  end

  assign card_clock_return = bp_clk;
  assign card_clock_return_oe_n = bp_oe_sync_q;

endmodule // rbt_transceiver

//--- shared/rbt_pkg.sv
package rbt_pkg;

  // Data path width of each direction
  localparam int unsigned DATA_W = 17;

  // Stages of every pin synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // Reset value of storage and data outputs
  localparam logic [DATA_W-1:0] DATA_RST = 17'h00000;

  // Reset level of the output enables: released, so the pins float
  localparam logic OE_N_RST = 1'b1;

  // Reset level of the sampled latch enables: closed
  localparam logic LE_RST = 1'b0;

  // Reset level of the sampled direction clocks and the forwarded clock
  localparam logic CLK_RST = 1'b0;

  // Direction indices
  localparam int unsigned DIR_AB = 0;
  localparam int unsigned DIR_BA = 1;
  localparam int unsigned DIR_N = 2;

endpackage

//--- sim/rbt_chk.sv
module rbt_chk #(
  parameter int unsigned WIDTH = 17
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] a_in_driven,
  input wire logic [WIDTH-1:0] a_out,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic [WIDTH-1:0] b_out,
  input wire logic b_oe_n,
  input wire logic a_to_b_output_enable_n,
  input wire logic a_to_b_latch_enable,
  input wire logic a_to_b_clock,
  input wire logic a_to_b_clock_enable_n,
  input wire logic b_to_a_latch_enable,
  input wire logic backplane_clock_copy,
  input wire logic backplane_clock_copy_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_run;
    (!sys_rst)[*4];
  endsequence
  sequence s_rise;
    $rose(a_to_b_clock) && !a_to_b_latch_enable && !a_to_b_clock_enable_n && &a_in_driven;
  endsequence
  a_transp_ab: assert property ((!sys_rst && a_to_b_latch_enable && &a_in_driven)[*5] |-> b_out == $past(a_in, 3))
    else $error("b_out not following a_in");
  a_transp_ba: assert property ((!sys_rst && b_to_a_latch_enable)[*5] |-> a_out == $past(b_in, 3))
    else $error("a_out not following b_in");
  a_clock_capture: assert property (s_rise |-> ##3 b_out == $past(a_in, 3))
    else $error("clock edge did not capture");
  a_inhibit_hold: assert property ((!sys_rst && !a_to_b_latch_enable && a_to_b_clock_enable_n)[*5] |-> $stable(b_out))
    else $error("b_out moved while inhibited");
  a_latch_hold: assert property ((!sys_rst && !a_to_b_latch_enable && $stable(a_to_b_clock))[*5] |-> $stable(b_out))
    else $error("b_out moved while latched");
  a_oe_follow: assert property (s_run |-> b_oe_n == $past(a_to_b_output_enable_n, 3))
    else $error("b_oe_n wrong");
  a_copy_clock: assert property (s_run |-> backplane_clock_copy == $past(a_to_b_clock, 3))
    else $error("clock copy wrong");
  a_copy_gate: assert property (s_run |-> backplane_clock_copy_oe_n == $past(a_to_b_output_enable_n, 3))
    else $error("clock copy enable wrong");
endmodule // rbt_chk

bind rbt_transceiver rbt_chk #(.WIDTH(WIDTH)) u_chk (.*);

//--- sim/rbt_bp_agent.sv
module rbt_bp_agent (
  output logic bp_clk,
  output logic [16:0] b_in,
  input wire logic [16:0] b_out,
  input wire logic b_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] val;
  initial
  begin
    val = 17'h1ffff;
    bp_clk = 1'b0;
    #7;
    forever #32 bp_clk = ~bp_clk;
  end
  task put(input logic [16:0] v);
    val = v;
  endtask
  // Far-side agents drive the lines while the device floats B
  assign b_in = b_oe_n ? val : b_out;
endmodule // rbt_bp_agent

//--- sim/rbt_transceiver_tb.sv
module rbt_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, bp_clk, a_oe_n, b_oe_n, card_clock_return, card_clock_return_oe_n;
  logic a_to_b_output_enable_n, a_to_b_latch_enable, a_to_b_clock, a_to_b_clock_enable_n;
  logic b_to_a_output_enable_n, b_to_a_latch_enable, b_to_a_clock, b_to_a_clock_enable_n;
  logic backplane_clock_copy, backplane_clock_copy_oe_n;
  logic [16:0] a_in, a_in_driven, a_out, b_in, b_out, a_v, a_drv;
  int fail_count = 0;
  int compares = 0;
  rbt_transceiver u_dut (.*);
  rbt_bp_agent u_bp (.*);
  // A wire: floating bits show the inverse of their last level
  assign a_in = !a_oe_n ? a_out : a_v ^ ~a_drv;
  assign a_in_driven = !a_oe_n ? 17'h1ffff : a_drv;
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input string s, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    final_report;
  end
  initial
  begin
    {sys_rst, a_to_b_output_enable_n, b_to_a_output_enable_n} = 3'b111;
    {a_to_b_latch_enable, a_to_b_clock, a_to_b_clock_enable_n} = 3'b000;
    {b_to_a_latch_enable, b_to_a_clock, b_to_a_clock_enable_n} = 3'b000;
    a_v = 17'h00000;
    a_drv = 17'h1ffff;
    cyc(8);
    sys_rst = 1'b0;
    cyc(4);
    chk("b_oe_n", 17'h1, b_oe_n);
    chk("a_oe_n", 17'h1, a_oe_n);
    a_to_b_output_enable_n = 1'b0;
    a_to_b_latch_enable = 1'b1;
    a_v = 17'h1a5a5;
    cyc(4);
    chk("transparent", 17'h1a5a5, b_out);
    chk("b_oe_n", 17'h0, b_oe_n);
    chk("copy oe", 17'h0, backplane_clock_copy_oe_n);
    a_to_b_latch_enable = 1'b0;
    cyc(1);
    a_v = 17'h0c3c3;
    cyc(5);
    chk("latched", 17'h1a5a5, b_out);
    a_to_b_clock = 1'b1;
    cyc(4);
    chk("clocked", 17'h0c3c3, b_out);
    chk("copy", 17'h1, backplane_clock_copy);
    a_to_b_clock = 1'b0;
    a_to_b_clock_enable_n = 1'b1;
    a_v = 17'h15555;
    cyc(4);
    a_to_b_clock = 1'b1;
    cyc(4);
    chk("inhibit", 17'h0c3c3, b_out);
    a_to_b_clock = 1'b0;
    a_to_b_clock_enable_n = 1'b0;
    cyc(4);
    a_drv = 17'h0ffff;
    cyc(1);
    a_v = 17'h10f0f;
    cyc(4);
    a_to_b_clock = 1'b1;
    cyc(4);
    chk("bus hold", 17'h10f0f, b_out);
    a_drv = 17'h1ffff;
    a_to_b_output_enable_n = 1'b1;
    cyc(1);
    b_to_a_output_enable_n = 1'b0;
    b_to_a_latch_enable = 1'b1;
    u_bp.put(17'h1c0de);
    cyc(7);
    chk("b to a", 17'h1c0de, a_out);
    chk("a_oe_n", 17'h0, a_oe_n);
    chk("isolated", 17'h1, b_oe_n);
    chk("copy oe off", 17'h1, backplane_clock_copy_oe_n);
    b_to_a_latch_enable = 1'b0;
    cyc(1);
    u_bp.put(17'h02468);
    cyc(5);
    chk("b to a latched", 17'h1c0de, a_out);
    b_to_a_clock = 1'b1;
    cyc(4);
    chk("b to a clocked", 17'h02468, a_out);
    cyc(20);
    chk("return oe", 17'h0, card_clock_return_oe_n);
    chk("return", bp_clk, card_clock_return);
    b_to_a_output_enable_n = 1'b1;
    #32;
    chk("return", bp_clk, card_clock_return);
    cyc(20);
    chk("return oe off", 17'h1, card_clock_return_oe_n);
    final_report;
  end
endmodule // rbt_transceiver_tb
